// ---- ccfg_clock_source_ctrl.sv ----
`timescale 1ns/1ns
// Function
// - Power field 01 puts loop in power-down
// - Power field 00 runs loop normally
// - Loop bank holds reference, divider, pump settings
// - Post-divider code selects divide 2 to 6
// - Bypass clear feeds distribution from post-divider
// - Bypass set routes source straight through
// - Source bit picks oscillator or external clock
// - Polarity bit picks positive or negative detector
// - Calibration starts when update turns bit from clear to set
// - Two-bit field sets antibacklash pulse width
// - Reset: loop off, divide 4, external source
module ccfg_clock_source_ctrl #(
    parameter int CAL_CYCLES = ccfg_pkg::CAL_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic                        clock,
    input  wire logic                        rst_n,
    // Register port
    input  wire logic [ccfg_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [ccfg_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic [ccfg_pkg::DATA_W-1:0]      reg_rdata,
    // Clock sources
    input  wire logic                        ext_clk_in,
    input  wire logic                        osc_clk_in,
    // Loop controls
    output logic [1:0]                       pll_power_mode,
    output logic                             pll_async_pd,
    output logic                             pll_run,
    output logic                             pfd_polarity_neg,
    output logic [1:0]                       antibacklash_width,
    output logic [8*ccfg_pkg::LOOP_NUM-1:0]  loop_cfg,
    // Path controls
    output logic                             osc_source_internal,
    output logic                             post_div_bypass,
    output logic [2:0]                       post_div_code,
    output logic                             dist_clk_out,
    // Calibration
    output logic                             cal_start,
    output logic                             cal_busy
);
    import ccfg_pkg::*;

    localparam int CW = $clog2(CAL_CYCLES + 1);

    logic [7:0]            loop_shadow [LOOP_NUM];
    logic [7:0]            loop_active [LOOP_NUM];
    logic [8*LOOP_NUM-1:0] loop_shadow_flat;
    logic [7:0]            div_shadow;
    logic [7:0]            div_active;
    logic [7:0]            path_shadow;
    logic [7:0]            path_active;
    logic                  loop_hit;
    logic [3:0]            loop_idx;
    logic                  upd_wr;
    logic                  upd_reg;
    logic [1:0]            pwr_mode_reg;
    logic                  async_pd_reg;
    logic                  run_reg;
    logic                  pol_reg;
    logic [1:0]            abl_reg;
    logic                  src_int_reg;
    logic                  bypass_reg;
    logic [2:0]            div_code_reg;
    logic                  dist_clk_reg;
    logic                  src_level;
    logic                  cal_act;
    logic                  cal_prev_reg;
    logic                  cal_rise;
    logic                  cal_start_reg;
    ccfg_cal_state_e       cal_state_reg;
    logic [CW-1:0]         cal_cnt_reg;
    logic                  cal_busy_reg;
    logic [7:0]            status;
    logic [7:0]            rdata_reg;

    // Address decode
    assign loop_hit = (reg_addr >= OFS_LOOP_FIRST) && (reg_addr <= OFS_LOOP_LAST);
    assign loop_idx = 4'(reg_addr - OFS_LOOP_FIRST);
    assign upd_wr   = reg_wr && (reg_addr == OFS_UPDATE) && reg_wdata[UPD_BIT];

    // Loop register bank
    genvar i;
    generate
        for (i = 0; i < LOOP_NUM; i++) begin : g_loop
            ccfg_shadow_reg #(
                .W   (8),
                .RST ((i == IDX_PWR) ? RST_LOOP_PWR : RST_LOOP_OTHER)
            ) u_reg (
                .clock      (clock),
                .rst_n      (rst_n),
                .wr_en      (reg_wr && loop_hit && (loop_idx == 4'(i))),
                .wr_data    (reg_wdata),
                .load       (upd_reg),
                .shadow_reg (loop_shadow[i]),
                .active_reg (loop_active[i])
            );
            assign loop_cfg[8*i +: 8]         = loop_active[i];
            assign loop_shadow_flat[8*i +: 8] = loop_shadow[i];
        end
    endgenerate

    // Post-divider ratio register
    ccfg_shadow_reg #(
        .W   (8),
        .RST (RST_POSTDIV)
    ) u_div (
        .clock      (clock),
        .rst_n      (rst_n),
        .wr_en      (reg_wr && (reg_addr == OFS_POSTDIV)),
        .wr_data    (reg_wdata),
        .load       (upd_reg),
        .shadow_reg (div_shadow),
        .active_reg (div_active)
    );

    // Source and path register
    ccfg_shadow_reg #(
        .W   (8),
        .RST (RST_PATH)
    ) u_path (
        .clock      (clock),
        .rst_n      (rst_n),
        .wr_en      (reg_wr && (reg_addr == OFS_PATH)),
        .wr_data    (reg_wdata),
        .load       (upd_reg),
        .shadow_reg (path_shadow),
        .active_reg (path_active)
    );

    // Update strobe, clears itself unless rewritten
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            upd_reg <= 1'b0;
        end else begin
            upd_reg <= upd_wr;
        end
    end

    // Loop control outputs
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pwr_mode_reg <= RST_LOOP_PWR[PWR_LSB +: PWR_W];
            async_pd_reg <= 1'b1;
            run_reg      <= 1'b0;
            pol_reg      <= RST_LOOP_OTHER[POL_BIT];
            abl_reg      <= RST_LOOP_OTHER[ABL_LSB +: ABL_W];
        end else begin
            pwr_mode_reg <= loop_active[IDX_PWR][PWR_LSB +: PWR_W];
            async_pd_reg <= loop_active[IDX_PWR][PWR_LSB +: PWR_W] == PWR_ASYNC_PD;
            run_reg      <= loop_active[IDX_PWR][PWR_LSB +: PWR_W] == PWR_NORMAL;
            pol_reg      <= loop_active[IDX_PWR][POL_BIT];
            abl_reg      <= loop_active[IDX_ANTIBL][ABL_LSB +: ABL_W];
        end
    end

    // Path control outputs
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            src_int_reg  <= RST_PATH[SRC_BIT];
            bypass_reg   <= RST_PATH[BYP_BIT];
            div_code_reg <= RST_POSTDIV[DIV_LSB +: DIV_W];
        end else begin
            src_int_reg  <= path_active[SRC_BIT];
            bypass_reg   <= path_active[BYP_BIT];
            div_code_reg <= div_active[DIV_LSB +: DIV_W];
        end
    end

    // Source select ahead of post-divider
    assign src_level = src_int_reg ? osc_clk_in : ext_clk_in;

    ccfg_post_div u_post_div (
        .clock        (clock),
        .rst_n        (rst_n),
        .src_level    (src_level),
        .ratio_code   (div_code_reg),
        .bypass       (bypass_reg),
        .dist_clk_reg (dist_clk_reg)
    );

    // Calibration trigger on rising effective bit
    assign cal_act  = loop_active[IDX_CAL][CAL_BIT];
    assign cal_rise = cal_act && !cal_prev_reg;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cal_prev_reg  <= 1'b0;
            cal_start_reg <= 1'b0;
        end else begin
            cal_prev_reg  <= cal_act;
            cal_start_reg <= cal_rise;
        end
    end

    // Calibration sequencer
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cal_state_reg <= CAL_IDLE;
            cal_cnt_reg   <= '0;
            cal_busy_reg  <= 1'b0;
        end else begin
            case (cal_state_reg)
                CAL_IDLE, CAL_DONE: begin
                    cal_cnt_reg  <= '0;
                    cal_busy_reg <= cal_start_reg;
                    if (cal_start_reg) begin
                        cal_state_reg <= CAL_RUN;
                    end else if (!cal_act) begin
                        cal_state_reg <= CAL_IDLE;
                    end
                end
                CAL_RUN: begin
                    if (cal_cnt_reg == CW'(CAL_CYCLES - 1)) begin
                        cal_state_reg <= CAL_DONE;
                        cal_cnt_reg   <= '0;
                        cal_busy_reg  <= 1'b0;
                    end else begin
                        cal_cnt_reg  <= CW'(cal_cnt_reg + 1'b1);
                        cal_busy_reg <= 1'b1;
                    end
                end
                default: begin
                    cal_state_reg <= CAL_IDLE;
                    cal_cnt_reg   <= '0;
                    cal_busy_reg  <= 1'b0;
                end
            endcase
        end
    end

    // Status word
    always_comb begin
        status              = 8'h00;
        status[ST_CAL_BUSY] = cal_state_reg == CAL_RUN;
        status[ST_CAL_DONE] = cal_state_reg == CAL_DONE;
        status[ST_UPD_PEND] = upd_reg;
        status[ST_PLL_RUN]  = run_reg;
    end

    // Read port, data valid one cycle after strobe
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
        end else if (reg_rd) begin
            if (loop_hit) begin
                rdata_reg <= loop_shadow[loop_idx];
            end else begin
                case (reg_addr)
                    OFS_POSTDIV: rdata_reg <= div_shadow;
                    OFS_PATH:    rdata_reg <= path_shadow;
                    OFS_STATUS:  rdata_reg <= status;
                    OFS_UPDATE:  rdata_reg <= 8'h00;
                    default:     rdata_reg <= 8'h00;
                endcase
            end
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    // Output drive
    assign reg_rdata           = rdata_reg;
    assign pll_power_mode      = pwr_mode_reg;
    assign pll_async_pd        = async_pd_reg;
    assign pll_run             = run_reg;
    assign pfd_polarity_neg    = pol_reg;
    assign antibacklash_width  = abl_reg;
    assign osc_source_internal = src_int_reg;
    assign post_div_bypass     = bypass_reg;
    assign post_div_code       = div_code_reg;
    assign dist_clk_out        = dist_clk_reg;
    assign cal_start           = cal_start_reg;
    assign cal_busy            = cal_busy_reg;

    // Checks
    sequence s_update;
        upd_reg;
    endsequence

    sequence s_cal_go;
        cal_start_reg ##1 (cal_state_reg == CAL_RUN);
    endsequence

    AST_UPD_PULSE: assert property (@(posedge clock) disable iff (!rst_n)
        upd_wr |=> upd_reg)
        else $error("update write not seen");
    AST_UPD_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
        !upd_wr |=> !upd_reg)
        else $error("update bit did not clear");
    AST_ASYNC_PD: assert property (@(posedge clock) disable iff (!rst_n)
        s_update ##0 (loop_shadow[IDX_PWR][1:0] == PWR_ASYNC_PD)
        |-> ##2 (pll_async_pd && !pll_run))
        else $error("loop not powered down");
    AST_NORMAL: assert property (@(posedge clock) disable iff (!rst_n)
        s_update ##0 (loop_shadow[IDX_PWR][1:0] == PWR_NORMAL)
        |-> ##2 (pll_run && !pll_async_pd))
        else $error("loop not running");
    AST_LOOP_CFG: assert property (@(posedge clock) disable iff (!rst_n)
        s_update |=> loop_cfg == $past(loop_shadow_flat))
        else $error("loop settings not transferred");
    AST_SRC_SEL: assert property (@(posedge clock) disable iff (!rst_n)
        s_update |-> ##2 osc_source_internal == $past(path_shadow[SRC_BIT], 2))
        else $error("source select wrong");
    AST_POLARITY: assert property (@(posedge clock) disable iff (!rst_n)
        s_update |-> ##2 pfd_polarity_neg == $past(loop_shadow_flat[POL_BIT], 2))
        else $error("detector polarity wrong");
    AST_ANTIBL: assert property (@(posedge clock) disable iff (!rst_n)
        s_update |-> ##2 antibacklash_width == $past(loop_shadow[IDX_ANTIBL][1:0], 2))
        else $error("antibacklash width wrong");
    AST_CAL_START: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(cal_act) |=> s_cal_go)
        else $error("calibration did not start");
    AST_CAL_NO_RETRIG: assert property (@(posedge clock) disable iff (!rst_n)
        !cal_rise |=> !cal_start)
        else $error("calibration restarted without rising bit");
    AST_RESET_VAL: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(rst_n) |-> (pll_async_pd && post_div_code == 3'h2
                          && !post_div_bypass && !osc_source_internal))
        else $error("reset defaults wrong");
endmodule // ccfg_clock_source_ctrl

// ---- ccfg_pkg.sv ----
package ccfg_pkg;
    // Bus geometry
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    // Register offsets
    localparam logic [9:0] OFS_LOOP_FIRST = 10'h010;
    localparam logic [9:0] OFS_LOOP_LAST  = 10'h01D;
    localparam logic [9:0] OFS_ANTIBL     = 10'h017;
    localparam logic [9:0] OFS_CAL        = 10'h018;
    localparam logic [9:0] OFS_POSTDIV    = 10'h1E0;
    localparam logic [9:0] OFS_PATH       = 10'h1E1;
    localparam logic [9:0] OFS_STATUS     = 10'h1F0;
    localparam logic [9:0] OFS_UPDATE     = 10'h232;
    // Loop register bank
    localparam int LOOP_NUM   = 14;
    localparam int IDX_PWR    = 0;
    localparam int IDX_ANTIBL = 7;
    localparam int IDX_CAL    = 8;
    // Field positions
    localparam int PWR_LSB = 0;
    localparam int PWR_W   = 2;
    localparam int POL_BIT = 7;
    localparam int ABL_LSB = 0;
    localparam int ABL_W   = 2;
    localparam int CAL_BIT = 0;
    localparam int DIV_LSB = 0;
    localparam int DIV_W   = 3;
    localparam int BYP_BIT = 0;
    localparam int SRC_BIT = 1;
    localparam int UPD_BIT = 0;
    // Status bits
    localparam int ST_CAL_BUSY = 0;
    localparam int ST_CAL_DONE = 1;
    localparam int ST_UPD_PEND = 2;
    localparam int ST_PLL_RUN  = 3;
    // Field values
    localparam logic [1:0] PWR_NORMAL   = 2'h0;
    localparam logic [1:0] PWR_ASYNC_PD = 2'h1;
    localparam logic [2:0] DIV_BASE     = 3'h2;
    localparam logic [2:0] DIV_CODE_MAX = 3'h4;
    localparam logic [2:0] DIV_RATIO_MAX = 3'h6;
    // Reset values
    localparam logic [7:0] RST_LOOP_PWR   = 8'h01;
    localparam logic [7:0] RST_LOOP_OTHER = 8'h00;
    localparam logic [7:0] RST_POSTDIV    = 8'h02;
    localparam logic [7:0] RST_PATH       = 8'h00;
    // Calibration run length in clock cycles
    localparam int CAL_CYCLES_DEF = 16;
    typedef enum logic [1:0] {
        CAL_IDLE = 2'h0,
        CAL_RUN  = 2'h1,
        CAL_DONE = 2'h3
    } ccfg_cal_state_e;
endpackage

// ---- ccfg_shadow_reg.sv ----
`timescale 1ns/1ns
module ccfg_shadow_reg #(
    parameter int         W   = 8,
    parameter logic [7:0] RST = 8'h00
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         rst_n,
    // Staging and transfer
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_data,
    input  wire logic         load,
    // Stored values
    output logic [W-1:0]      shadow_reg,
    output logic [W-1:0]      active_reg
);
    import ccfg_pkg::*;

    // Staged value
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            shadow_reg <= RST[W-1:0];
        end else if (wr_en) begin
            shadow_reg <= wr_data;
        end
    end

    // Effective value
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            active_reg <= RST[W-1:0];
        end else if (load) begin
            active_reg <= shadow_reg;
        end
    end

    AST_LOAD_COPIES: assert property (@(posedge clock) disable iff (!rst_n)
        load |=> active_reg == $past(shadow_reg))
        else $error("active value not taken from staged value");
    AST_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
        !load |=> $stable(active_reg))
        else $error("active value changed without update");
endmodule // ccfg_shadow_reg

// ---- ccfg_post_div.sv ----
`timescale 1ns/1ns
module ccfg_post_div (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // Source and setting
    input  wire logic       src_level,
    input  wire logic [2:0] ratio_code,
    input  wire logic       bypass,
    // Distribution feed
    output logic            dist_clk_reg
);
    import ccfg_pkg::*;

    logic       src_prev_reg;
    logic [2:0] cnt_reg;
    logic [2:0] ratio;
    logic [2:0] half;
    logic       src_rise;

    // Ratio 2 to 6, codes above range divide by 6
    assign ratio = (ratio_code > DIV_CODE_MAX) ? DIV_RATIO_MAX
                                               : 3'(ratio_code + DIV_BASE);
    assign half = ratio >> 1;
    assign src_rise = src_level & ~src_prev_reg;

    // Source edge detect
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            src_prev_reg <= 1'b0;
        end else begin
            src_prev_reg <= src_level;
        end
    end

    // Edge counter
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt_reg <= 3'h0;
        end else if (src_rise) begin
            if (cnt_reg >= 3'(ratio - 3'h1)) begin
                cnt_reg <= 3'h0;
            end else begin
                cnt_reg <= 3'(cnt_reg + 3'h1);
            end
        end
    end

    // Output path select
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dist_clk_reg <= 1'b0;
        end else if (bypass) begin
            dist_clk_reg <= src_level;
        end else begin
            dist_clk_reg <= (cnt_reg < half);
        end
    end

    AST_BYPASS_FOLLOWS: assert property (@(posedge clock) disable iff (!rst_n)
        bypass |=> dist_clk_reg == $past(src_level))
        else $error("bypassed output does not follow source");
    AST_DIV_LOW: assert property (@(posedge clock) disable iff (!rst_n)
        !bypass && cnt_reg >= half |=> !dist_clk_reg)
        else $error("divided output high in low phase");
    AST_CNT_RANGE: assert property (@(posedge clock) disable iff (!rst_n)
        cnt_reg < DIV_RATIO_MAX)
        else $error("divider count out of range");
endmodule // ccfg_post_div

// ---- ccfg_testbench.sv ----
`timescale 1ns/1ns
module testbench;
    import ccfg_pkg::*;
    localparam int CALN = 4;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [9:0]  reg_addr = 10'h000;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic        ext_clk_in = 1'b0;
    logic        osc_clk_in = 1'b0;
    logic [1:0]  pll_power_mode;
    logic        pll_async_pd;
    logic        pll_run;
    logic        pfd_polarity_neg;
    logic [1:0]  antibacklash_width;
    logic [111:0] loop_cfg;
    logic        osc_source_internal;
    logic        post_div_bypass;
    logic [2:0]  post_div_code;
    logic        dist_clk_out;
    logic        cal_start;
    logic        cal_busy;
    logic        dist_prev = 1'b0;
    int          dist_rises = 0;
    int          n_fail = 0;
    int          n_compared = 0;

    always #5 clock = ~clock;

    ccfg_clock_source_ctrl #(.CAL_CYCLES(CALN)) DUT (
        .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ext_clk_in(ext_clk_in), .osc_clk_in(osc_clk_in),
        .pll_power_mode(pll_power_mode), .pll_async_pd(pll_async_pd), .pll_run(pll_run),
        .pfd_polarity_neg(pfd_polarity_neg), .antibacklash_width(antibacklash_width),
        .loop_cfg(loop_cfg), .osc_source_internal(osc_source_internal),
        .post_div_bypass(post_div_bypass), .post_div_code(post_div_code),
        .dist_clk_out(dist_clk_out), .cal_start(cal_start), .cal_busy(cal_busy)
    );

    // Rising edges of the distribution feed
    always @(negedge clock) begin
        dist_prev <= dist_clk_out;
        if (dist_clk_out === 1'b1 && dist_prev === 1'b0)
            dist_rises = dist_rises + 1;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1;
        chk($sformatf("read %h", a), {24'h0, exp}, {24'h0, reg_rdata});
    endtask

    // Update write, then let the derived outputs settle
    task automatic upd();
        wr(OFS_UPDATE, 8'h01);
        repeat (4) @(posedge clock);
        #1;
    endtask

    // Toggle one source for a number of periods, count feed edges
    task automatic run_src(input bit use_osc, input int periods, input int exp, input int tol);
        int d;
        dist_rises = 0;
        for (int i = 0; i < 2 * periods; i++) begin
            repeat (2) @(posedge clock);
            if (use_osc)
                osc_clk_in <= ~osc_clk_in;
            else
                ext_clk_in <= ~ext_clk_in;
        end
        repeat (4) @(posedge clock);
        d = dist_rises - exp;
        n_compared++;
        if (d > tol || d < -tol) begin
            n_fail++;
            $display("CHECK FAILED dist rises expected %0d seen %0d", exp, dist_rises);
        end
    endtask

    // Wait for a calibration start, then measure the busy span
    task automatic cal_run(input logic expect_start);
        int n;
        logic seen;
        seen = 1'b0;
        n = 0;
        for (int i = 0; i < 8 && !seen; i++) begin
            @(posedge clock);
            #1;
            seen = cal_start;
        end
        chk("cal_start", {31'h0, expect_start}, {31'h0, seen});
        if (seen) begin
            for (int i = 0; i < 40; i++) begin
                @(posedge clock);
                #1;
                if (cal_busy === 1'b1)
                    n++;
            end
            chk("cal_busy cycles", CALN, n);
        end
    endtask

    task automatic final_report();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        final_report();
    end

    initial begin
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        #1;
        chk("async_pd", 1, pll_async_pd);
        chk("pll_run", 0, pll_run);
        chk("code", 2, post_div_code);
        chk("bypass", 0, post_div_bypass);
        chk("osc", 0, osc_source_internal);
        rd(OFS_LOOP_FIRST, 8'h01);
        rd(OFS_POSTDIV, 8'h02);
        rd(OFS_PATH, 8'h00);
        rd(10'h3FF, 8'h00);
        rd(OFS_UPDATE, 8'h00);
        $display("test reset done");

        wr(OFS_LOOP_FIRST, 8'h80);
        wr(OFS_ANTIBL, 8'h03);
        wr(OFS_LOOP_LAST, 8'h5A);
        wr(OFS_POSTDIV, 8'h04);
        wr(OFS_PATH, 8'h03);
        wr(10'h3FF, 8'hFF);
        repeat (4) @(posedge clock);
        #1;
        chk("staged async_pd", 1, pll_async_pd);
        chk("staged code", 2, post_div_code);
        rd(OFS_LOOP_FIRST, 8'h80);
        rd(10'h3FF, 8'h00);
        upd();
        chk("pll_run", 1, pll_run);
        chk("async_pd", 0, pll_async_pd);
        chk("mode", PWR_NORMAL, pll_power_mode);
        chk("polarity", 1, pfd_polarity_neg);
        chk("antibacklash", 3, antibacklash_width);
        chk("code", 4, post_div_code);
        chk("bypass", 1, post_div_bypass);
        chk("osc", 1, osc_source_internal);
        chk("loop byte0", 8'h80, loop_cfg[7:0]);
        chk("loop byte7", 8'h03, loop_cfg[63:56]);
        chk("loop byte13", 8'h5A, loop_cfg[111:104]);
        rd(OFS_STATUS, 8'h08);
        wr(OFS_LOOP_FIRST, 8'h01);
        upd();
        chk("async_pd", 1, pll_async_pd);
        chk("pll_run", 0, pll_run);
        chk("polarity", 0, pfd_polarity_neg);
        $display("test staging done");

        run_src(1'b1, 20, 20, 1);
        run_src(1'b0, 20, 0, 0);
        wr(OFS_PATH, 8'h01);
        wr(OFS_LOOP_FIRST, 8'h00);
        upd();
        chk("pll_run", 1, pll_run);
        run_src(1'b0, 20, 20, 1);
        run_src(1'b1, 20, 0, 0);
        for (int c = 0; c < 8; c++) begin
            if (c < 5 || c == 7) begin
                wr(OFS_POSTDIV, c[7:0]);
                wr(OFS_PATH, 8'h00);
                upd();
                run_src(1'b0, 120, 120 / ((c > 4) ? 6 : c + 2), 1);
            end
        end
        $display("test path done");

        wr(OFS_PATH, 8'h02);
        wr(OFS_CAL, 8'h01);
        wr(OFS_UPDATE, 8'h01);
        cal_run(1'b1);
        chk("osc", 1, osc_source_internal);
        wr(OFS_UPDATE, 8'h01);
        cal_run(1'b0);
        wr(OFS_CAL, 8'h00);
        upd();
        wr(OFS_CAL, 8'h01);
        wr(OFS_UPDATE, 8'h01);
        cal_run(1'b1);
        rd(OFS_STATUS, 8'h0A);
        wr(OFS_STATUS, 8'h00);
        rd(OFS_STATUS, 8'h0A);
        $display("test calibration done");
        final_report();
    end
endmodule // testbench
